/* File: common/ccsm_pkg.sv */
// shared constants, types and register map of the config set manager
package ccsm_pkg;

  // ----------------------------------------------------------------
  // parameter set layout
  // ----------------------------------------------------------------
  localparam int CCSM_WORDS = 8;
  localparam int CCSM_IDX_W = 3;
  localparam logic [CCSM_IDX_W-1:0] CCSM_W_GAIN = 3'h0;
  localparam logic [CCSM_IDX_W-1:0] CCSM_W_AUTO = 3'h1;
  localparam logic [CCSM_IDX_W-1:0] CCSM_W_LUT = 3'h7;

  // gain word: low baseline and +6 dB baseline (raw gain units)
  localparam logic [15:0] CCSM_GAIN_LOW = 16'h0000;
  localparam logic [15:0] CCSM_GAIN_6DB = 16'h0040;
  // auto word bit fields
  localparam int CCSM_AUTO_GAIN_BIT = 0;
  localparam int CCSM_AUTO_EXP_BIT = 1;
  localparam int CCSM_AUTO_CONT_BIT = 2;
  localparam int CCSM_AUTO_MINGAIN_BIT = 3;
  localparam logic [15:0] CCSM_AUTO_OFF = 16'h0000;
  localparam logic [15:0] CCSM_AUTO_ON = 16'h000F;
  localparam logic [15:0] CCSM_WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CCSM_REG_CTRL = 8'h00;
  localparam logic [7:0] CCSM_REG_SEL = 8'h04;
  localparam logic [7:0] CCSM_REG_STAT = 8'h08;
  localparam logic [7:0] CCSM_REG_ACT0 = 8'h20;
  localparam int CCSM_CTRL_SAVE_BIT = 0;
  localparam int CCSM_CTRL_LOAD_BIT = 1;
  localparam int CCSM_SEL_USER_LSB = 0;
  localparam int CCSM_SEL_FAC_LSB = 2;
  localparam int CCSM_SEL_BOOT_LSB = 4;
  localparam int CCSM_STAT_STATE_LSB = 0;
  localparam int CCSM_STAT_IDLE_BIT = 3;

  // ----------------------------------------------------------------
  // selector encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCSM_SLOT_DEFAULT = 2'b00,
    CCSM_SLOT_USER1 = 2'b01,
    CCSM_SLOT_USER2 = 2'b10,
    CCSM_SLOT_USER3 = 2'b11
  } ccsm_slot_t;

  typedef enum logic [1:0] {
    CCSM_FAC_STANDARD = 2'b00,
    CCSM_FAC_HIGHGAIN = 2'b01,
    CCSM_FAC_AUTO = 2'b10
  } ccsm_fac_t;

  typedef enum logic [1:0] {
    CCSM_ST_BOOT = 2'b00,
    CCSM_ST_IDLE = 2'b01,
    CCSM_ST_LOAD = 2'b10,
    CCSM_ST_SAVE = 2'b11
  } ccsm_state_t;

  localparam logic [1:0] CCSM_SLOT_RST = 2'b00;
  localparam logic [1:0] CCSM_FAC_RST = 2'b00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ccsm_bus_t;

  // persistent store image, kept outside in non-volatile memory
  typedef struct packed {
    logic [1:0] boot_sel;
    logic [1:0] fac_sel;
  } ccsm_nv_t;

endpackage : ccsm_pkg

/* File: design/ccsm_top.sv */
// camera configuration set manager: active, factory, user and boot sets
//
// Behaviour
// - The working set lives in flops cleared by reset and takes edits written while the sequencer is idle.
// - Three factory sets are constants that no command can change.
// - The standard factory set has low gain and all auto functions off.
// - The high-gain factory set is the standard one with gain +6 dB.
// - The auto factory set enables continuous auto gain/exposure, min gain.
// - The default-set choice is held in non-volatile storage.
// - The default-set choice is standard when delivered.
// - Three non-volatile user slots 1..3 hold saved sets.
// - Store copies the working set, except the lookup-table word, into the selected user slot.
// - The lookup-table word is never stored nor restored.
// - Recall overwrites the working set from the selected slot or default.
// - Recall is honoured only while the camera is idle.
// - Default-set choice may change only while idle.
// - A persistent boot-set choice names slot 1..3 or the default set.
// - After reset the boot set is copied into the working set first.
`timescale 1ns/100ps
module ccsm_top #(
  parameter int WORDS = ccsm_pkg::CCSM_WORDS
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire ccsm_pkg::ccsm_bus_t bus_in,
  output logic [31:0] rdata_out,
  // acquisition status
  input wire logic acq_cont_in,
  input wire logic acq_pend_in,
  // persistent selector image in non-volatile storage
  input wire ccsm_pkg::ccsm_nv_t nv_in,
  output ccsm_pkg::ccsm_nv_t nv_out,
  output logic nv_we_out,
  // working set to the camera
  output logic [WORDS*16-1:0] active_out,
  output logic ready_out
);
  import ccsm_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta, rst_n;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] active [WORDS];
  // user slots model non-volatile areas: no reset touches them
  logic [15:0] user_mem [3][WORDS];
  logic [1:0] user_sel;
  ccsm_nv_t nv;
  ccsm_state_t state;
  logic [CCSM_IDX_W-1:0] idx;
  logic [1:0] src_sel;
  logic idle;

  assign idle = !acq_cont_in && !acq_pend_in;

  // factory image word, fixed in logic
  function automatic logic [15:0] fac_word(
    input logic [1:0] fac, input logic [CCSM_IDX_W-1:0] i);
    logic [15:0] w;
    w = CCSM_WORD_RST;
    if (i == CCSM_W_GAIN) begin
      w = CCSM_GAIN_LOW;
      if (fac == CCSM_FAC_HIGHGAIN) begin
        w = CCSM_GAIN_6DB;
      end
    end
    if (i == CCSM_W_AUTO) begin
      w = (fac == CCSM_FAC_AUTO) ? CCSM_AUTO_ON : CCSM_AUTO_OFF;
    end
    return w;
  endfunction : fac_word

  // source word for a load from slot or default
  function automatic logic [15:0] src_word(
    input logic [1:0] s, input logic [1:0] fac,
    input logic [CCSM_IDX_W-1:0] i);
    logic [15:0] w;
    w = CCSM_WORD_RST;
    if (s == CCSM_SLOT_DEFAULT) begin
      w = fac_word(fac, i);
    end else begin
      w = user_mem[s - 2'h1][i];
    end
    return w;
  endfunction : src_word

  // code 3 names no factory set
  function automatic logic fac_legal(input logic [1:0] f);
    logic ok;
    ok = f != 2'h3;
    return ok;
  endfunction : fac_legal

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic hit_ctrl, hit_sel, hit_stat;
  logic wr_ctrl, wr_sel, wr_act, act_hit;
  logic [CCSM_IDX_W-1:0] act_idx;
  assign hit_ctrl = bus_in.addr == CCSM_REG_CTRL;
  assign hit_sel = bus_in.addr == CCSM_REG_SEL;
  assign hit_stat = bus_in.addr == CCSM_REG_STAT;
  assign wr_ctrl = bus_in.wr && hit_ctrl;
  assign wr_sel = bus_in.wr && hit_sel;
  assign act_hit = bus_in.addr >= CCSM_REG_ACT0 &&
                   bus_in.addr < CCSM_REG_ACT0 + 8'(WORDS * 4) &&
                   bus_in.addr[1:0] == 2'b00;
  assign act_idx = CCSM_IDX_W'((bus_in.addr - CCSM_REG_ACT0) >> 2);
  assign wr_act = bus_in.wr && act_hit && state == CCSM_ST_IDLE;

  // ----------------------------------------------------------------
  // selector fields
  // ----------------------------------------------------------------
  logic [1:0] wr_user, wr_fac, wr_boot;
  assign wr_user = bus_in.wdata[CCSM_SEL_USER_LSB +: 2];
  assign wr_fac = bus_in.wdata[CCSM_SEL_FAC_LSB +: 2];
  assign wr_boot = bus_in.wdata[CCSM_SEL_BOOT_LSB +: 2];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic go_save, go_load;
  assign go_save = wr_ctrl && bus_in.wdata[CCSM_CTRL_SAVE_BIT] &&
                   state == CCSM_ST_IDLE && user_sel != CCSM_SLOT_DEFAULT;
  // busy load ignored
  // save wins when both bits are set and a user slot is selected
  assign go_load = wr_ctrl && bus_in.wdata[CCSM_CTRL_LOAD_BIT] &&
                   !go_save && state == CCSM_ST_IDLE && idle;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= CCSM_ST_BOOT;
      idx <= '0;
      src_sel <= CCSM_SLOT_RST;
    end else begin
      unique case (state)
        CCSM_ST_BOOT: begin
          src_sel <= nv_in.boot_sel;
          idx <= '0;
          state <= CCSM_ST_LOAD;
        end
        CCSM_ST_IDLE: begin
          idx <= '0;
          if (go_save) begin
            src_sel <= user_sel;
            state <= CCSM_ST_SAVE;
          end else if (go_load) begin
            src_sel <= user_sel;
            state <= CCSM_ST_LOAD;
          end
        end
        CCSM_ST_LOAD, CCSM_ST_SAVE: begin
          idx <= idx + 1'b1;
          if (idx == CCSM_IDX_W'(WORDS - 1)) begin
            state <= CCSM_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // working set
  // ----------------------------------------------------------------
  // volatile, edits land here
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        active[i] <= CCSM_WORD_RST;
      end
    end else if (state == CCSM_ST_LOAD) begin
      if (idx != CCSM_W_LUT) begin
        active[idx] <= src_word(src_sel, nv.fac_sel, idx);
      end
    end else if (wr_act) begin
      active[act_idx] <= bus_in.wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // user slots
  // ----------------------------------------------------------------
  // three persistent slots
  always_ff @(posedge core_clk_in) begin
    if (state == CCSM_ST_SAVE && idx != CCSM_W_LUT) begin
      user_mem[src_sel - 2'h1][idx] <= active[idx];
    end
  end

  // ----------------------------------------------------------------
  // selectors
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      user_sel <= CCSM_SLOT_RST;
    end else if (wr_sel && state == CCSM_ST_IDLE) begin
      user_sel <= wr_user;
    end
  end

  // persistent choices mirrored from storage; writes go back out
  logic fac_ok;
  assign fac_ok = wr_sel && state == CCSM_ST_IDLE && idle &&
                  fac_legal(wr_fac);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nv <= '{boot_sel: CCSM_SLOT_RST, fac_sel: CCSM_FAC_RST};
      nv_we_out <= 1'b0;
    end else begin
      nv_we_out <= 1'b0;
      if (state == CCSM_ST_BOOT) begin
        nv.boot_sel <= nv_in.boot_sel;
        // junk in storage falls back to standard
        if (fac_legal(nv_in.fac_sel)) begin
          nv.fac_sel <= nv_in.fac_sel;
        end else begin
          nv.fac_sel <= CCSM_FAC_STANDARD;
        end
      end else if (wr_sel && state == CCSM_ST_IDLE) begin
        nv.boot_sel <= wr_boot;
        if (fac_ok) begin
          nv.fac_sel <= wr_fac;
        end
        nv_we_out <= 1'b1;
      end
    end
  end
  assign nv_out = nv;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [31:0] sel_word, stat_word;
  always_comb begin
    sel_word = '0;
    sel_word[CCSM_SEL_USER_LSB +: 2] = user_sel;
    sel_word[CCSM_SEL_FAC_LSB +: 2] = nv.fac_sel;
    sel_word[CCSM_SEL_BOOT_LSB +: 2] = nv.boot_sel;
    stat_word = '0;
    stat_word[CCSM_STAT_STATE_LSB +: 2] = state;
    stat_word[CCSM_STAT_IDLE_BIT] = idle;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      rdata_out <= '0;
      if (hit_sel) begin
        rdata_out <= sel_word;
      end else if (hit_stat) begin
        rdata_out <= stat_word;
      end else if (act_hit) begin
        rdata_out <= {16'h0, active[act_idx]};
      end
    end else begin
      rdata_out <= '0;
    end
  end

  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      active_out[i*16 +: 16] = active[i];
    end
  end
  assign ready_out = state == CCSM_ST_IDLE;

endmodule : ccsm_top

/* File: tb/ccsm_top_props.sv */
// assertion checker for the config set manager ports
`timescale 1ns/100ps
module ccsm_top_props #(
  parameter int WORDS = 8
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // observed ports
  input wire ccsm_pkg::ccsm_bus_t bus_in,
  input wire logic [31:0] rdata_out,
  input wire logic acq_cont_in,
  input wire logic acq_pend_in,
  input wire ccsm_pkg::ccsm_nv_t nv_in,
  input wire ccsm_pkg::ccsm_nv_t nv_out,
  input wire logic nv_we_out,
  input wire logic [WORDS*16-1:0] active_out,
  input wire logic ready_out
);
  import ccsm_pkg::*;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [4:0] cyc;
  logic busy, sel_wr, ctl, ld_req, sv_req;
  assign busy = acq_cont_in | acq_pend_in;
  assign sel_wr = bus_in.wr & (bus_in.addr == CCSM_REG_SEL) & ready_out;
  assign ctl = bus_in.wr & (bus_in.addr == CCSM_REG_CTRL) & ready_out;
  assign ld_req = ctl & bus_in.wdata[1] & ~bus_in.wdata[0];
  assign sv_req = ctl & bus_in.wdata[0];
  // cycles since release, saturating so boot checks fire once
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc <= 5'h00;
    end else if (cyc != 5'h1F) begin
      cyc <= cyc + 5'h01;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_boot_hold;
    cyc < 5'h09 |-> !ready_out;
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("ready before boot copy");
  property p_boot_done;
    $rose(ready_out) && cyc < 5'h1F |-> cyc >= 5'h0A && cyc <= 5'h0E;
  endproperty
  a_boot_done: assert property (p_boot_done)
    else $error("boot copy length wrong");
  property p_load_len;
    ld_req && !busy |=> !ready_out [*8] ##1 ready_out;
  endproperty
  a_load_len: assert property (p_load_len)
    else $error("load length wrong");
  property p_load_busy;
    ld_req && busy |=> ready_out && $stable(active_out);
  endproperty
  a_load_busy: assert property (p_load_busy)
    else $error("load taken while busy");
  property p_lut_keep;
    ld_req && !busy |=> $stable(active_out[WORDS*16-1 -: 16]) [*8];
  endproperty
  a_lut_keep: assert property (p_lut_keep)
    else $error("lookup word changed by load");
  property p_save_hold;
    sv_req |=> $stable(active_out) [*8];
  endproperty
  a_save_hold: assert property (p_save_hold)
    else $error("working set changed by save");
  property p_fac_keep;
    sel_wr && busy |=> nv_out.fac_sel == $past(nv_out.fac_sel);
  endproperty
  a_fac_keep: assert property (p_fac_keep)
    else $error("default choice changed while busy");
  property p_fac_take;
    sel_wr && !busy && bus_in.wdata[3:2] != 2'h3
      |=> nv_out.fac_sel == $past(bus_in.wdata[3:2]);
  endproperty
  a_fac_take: assert property (p_fac_take)
    else $error("default choice not taken");
  property p_boot_take;
    sel_wr |=> nv_out.boot_sel == $past(bus_in.wdata[5:4]);
  endproperty
  a_boot_take: assert property (p_boot_take)
    else $error("boot choice not taken");
  property p_rd_quiet;
    !$past(bus_in.rd) |-> rdata_out == 32'h0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside read slot");
  property p_nv_we;
    nv_we_out == $past(sel_wr);
  endproperty
  a_nv_we: assert property (p_nv_we)
    else $error("persist strobe wrong");
  c_load: cover property (ld_req && !busy);
  c_save: cover property (sv_req);
  c_busy: cover property (ld_req && busy);
endmodule : ccsm_top_props

bind ccsm_top ccsm_top_props #(.WORDS(WORDS)) u_props (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .acq_cont_in(acq_cont_in),
  .acq_pend_in(acq_pend_in), .nv_in(nv_in), .nv_out(nv_out),
  .nv_we_out(nv_we_out), .active_out(active_out), .ready_out(ready_out));

/* File: tb/tb.sv */
// self-checking bench for the config set manager
`timescale 1ns/100ps
module tb;
  import ccsm_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  ccsm_bus_t bus_in = '0;
  logic acq_cont_in = 1'b0;
  logic acq_pend_in = 1'b0;
  ccsm_nv_t nv_in = '{boot_sel: 2'h0, fac_sel: 2'h1};
  logic [31:0] rdata_out, rdat;
  ccsm_nv_t nv_out;
  logic nv_we_out, ready_out;
  logic [CCSM_WORDS*16-1:0] active_out;
  logic [1:0] boot = 2'h0, fac = 2'h1;
  int fails = 0;
  int compares = 0;
  int seed = 7072;
  int act[8];
  int slot[4][8];

  always #2.5 core_clk_in = ~core_clk_in;

  ccsm_top #(.WORDS(CCSM_WORDS)) u_dut (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .acq_cont_in(acq_cont_in), .acq_pend_in(acq_pend_in), .nv_in(nv_in),
    .nv_out(nv_out), .nv_we_out(nv_we_out), .active_out(active_out),
    .ready_out(ready_out));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      fails++;
    end
  endtask : check
  // one gap cycle between strobes keeps drivers race free
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    @(posedge core_clk_in);
    bus_in <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk_in);
    bus_in <= '0;
    #1 rdat = rdata_out;
  endtask : bus
  task automatic sel(input logic [1:0] u, f);
    bus(1'b1, CCSM_REG_SEL, {26'h0, boot, f, u});
    check("nv_we", 32'h1, {31'h0, nv_we_out});
  endtask : sel
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_out !== 1'b1 && n < 40) begin
      @(posedge core_clk_in);
      #1 n++;
    end
    check("ready", 32'h1, {31'h0, ready_out});
  endtask : wait_ready
  task automatic check_act(input string nm);
    for (int i = 0; i < 8; i++) begin
      if (act[i] >= 0) check(nm, act[i], {16'h0, active_out[16*i+:16]});
    end
  endtask : check_act
  task automatic rand_act();
    for (int i = 0; i < 8; i++) begin
      act[i] = $random(seed) & 32'hFFFF;
      bus(1'b1, CCSM_REG_ACT0 + 8'(4 * i), act[i]);
    end
  endtask : rand_act
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #200000;
    fails++;
    $display("[ERR] watchdog exp done got hang");
    test_done();
  end

  initial begin
    repeat (16) @(posedge core_clk_in);
    check("nv_rst", 32'h0, {28'h0, nv_out});
    rst_n_in <= 1'b1;
    wait_ready();
    act = '{CCSM_GAIN_6DB, CCSM_AUTO_OFF, -1, -1, -1, -1, -1, 0};
    check_act("boot");
    bus(1'b0, CCSM_REG_SEL, 0);
    check("sel", 32'h4, rdat);
    bus(1'b0, CCSM_REG_STAT, 0);
    check("stat", 32'h9, rdat);
    $display("test boot done");
    for (int k = 0; k < 4; k++) begin
      rand_act();
      sel(2'(k % 3 + 1), fac);
      bus(1'b1, CCSM_REG_CTRL, 1);
      wait_ready();
      slot[k % 3 + 1] = act;
    end
    rand_act();
    for (int s = 3; s > 0; s--) begin
      sel(2'(s), fac);
      bus(1'b1, CCSM_REG_CTRL, 2);
      wait_ready();
      for (int i = 0; i < 7; i++) act[i] = slot[s][i];
      check_act("user_load");
      bus(1'b0, CCSM_REG_ACT0, 0);
      check("act0_rd", act[0], rdat);
    end
    $display("test user sets done");
    for (int f = 0; f < 3; f++) begin
      fac = 2'(f);
      sel(2'h0, fac);
      bus(1'b1, CCSM_REG_CTRL, 2);
      wait_ready();
      act[0] = (f == 1) ? CCSM_GAIN_6DB : CCSM_GAIN_LOW;
      act[1] = (f == 2) ? CCSM_AUTO_ON : CCSM_AUTO_OFF;
      for (int i = 2; i < 7; i++) act[i] = -1;
      check_act("default_load");
      check("fac", 32'(f), {30'h0, nv_out.fac_sel});
    end
    $display("test factory sets done");
    for (int b = 0; b < 2; b++) begin
      @(posedge core_clk_in);
      acq_cont_in <= (b == 0);
      acq_pend_in <= (b == 1);
      sel(2'h1, 2'((fac + 1) % 3));
      bus(1'b1, CCSM_REG_CTRL, 2);
      check("busy_rdy", 32'h1, {31'h0, ready_out});
      check_act("busy_load");
      bus(1'b0, CCSM_REG_SEL, 0);
      check("busy_fac", 32'(fac), {30'h0, rdat[3:2]});
      bus(1'b0, CCSM_REG_STAT, 0);
      check("busy_stat", 32'h1, rdat);
    end
    acq_cont_in <= 1'b0;
    acq_pend_in <= 1'b0;
    $display("test busy done");
    rand_act();
    @(posedge core_clk_in);
    nv_in <= '{boot_sel: 2'h2, fac_sel: 2'h0};
    rst_n_in <= 1'b0;
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    wait_ready();
    for (int i = 0; i < 7; i++) act[i] = slot[2][i];
    act[7] = 0;
    check_act("reboot");
    check("nv_boot", 32'h8, {28'h0, nv_out});
    $display("test reboot done");
    test_done();
  end
endmodule : tb
